// File: common/adcsq_pkg.sv
// Purpose: Constants shared by the converter sequencer control block.
// Assumes: 8-bit special function register bus, CPU clock CLK.
// Notes:   All offsets, single-bit field positions and reset values live here.
//
// Summary of operation
// [RULE1] Writing start bit 7 high, low, high starts one conversion unless continuous.
// [RULE2] The start bit is resynchronised to the converter clock before use.
// [RULE3] Continuous-run bit 6 converts back to back and ignores the start bit.
// [RULE4] Power bit 5 at zero holds the converter powered down.
// [RULE5] Bit 4 picks external reference when one, ignored for the supply channel.
// [RULE6] Channel field 3..0 picks inputs 0..7; value 8 picks supply/3, internal ref.
// [RULE7] Static bit 7 selects differential measurement against input 0.
// [RULE8] Static bit 6 puts the converter in reduced power mode.
// [RULE9] Static bit 5 selects converter clock CPU/32 when zero, CPU/8 when one.
// [RULE10] Static bits 4..2 trim the bias current; left at reset value normally.
// [RULE11] Resolution field 1..0 selects 6, 8, 10 or 12 bit conversion.
// [RULE12] Six-bit results sit in high byte bits 5..0, bits 7..6 read zero.
// [RULE13] Ten and twelve bit low parts sit left-justified in low byte 7..6 or 7..4.
// [RULE14] Underflow sets low byte bit 2 and gives an all-zero result.
// [RULE15] Overflow sets low byte bit 1 and gives an all-ones result.
// [RULE16] Low byte bit 0 is underflow OR overflow.
// [RULE17] A completed conversion sets end-of-conversion flag, interrupt flag bit 4.
// [RULE18] After reset control holds 0x80 and static holds 0x0A.
// [RULE19] The converter resolves two result bits per converter clock cycle.
// [RULE20] The end-of-conversion flag feeds the extended interrupt unit.
// [RULE21] Software clears the end-of-conversion flag by writing zero before reuse.

package adcsq_pkg;

	// ***************************************************************
	// Register addresses and reset values
	// ***************************************************************
	localparam logic [7:0] ADCSQ_ADDR_CONTROL = 8'hA1;
	localparam logic [7:0] ADCSQ_ADDR_HIGH    = 8'hA2;
	localparam logic [7:0] ADCSQ_ADDR_LOW     = 8'hA3;
	localparam logic [7:0] ADCSQ_ADDR_STATIC  = 8'hA4;
	localparam logic [7:0] ADCSQ_ADDR_EXTIRQ  = 8'h91;
	localparam logic [7:0] ADCSQ_CONTROL_RST  = 8'h80;
	localparam logic [7:0] ADCSQ_STATIC_RST   = 8'h0A;

	// ***************************************************************
	// Field positions
	// ***************************************************************
	localparam int ADCSQ_BIT_START    = 7;
	localparam int ADCSQ_BIT_RUN      = 6;
	localparam int ADCSQ_BIT_POWER    = 5;
	localparam int ADCSQ_BIT_REF      = 4;
	localparam int ADCSQ_BIT_DIFF     = 7;
	localparam int ADCSQ_BIT_SLEEP    = 6;
	localparam int ADCSQ_BIT_FAST     = 5;
	localparam int ADCSQ_BIT_EOC      = 4;
	localparam int ADCSQ_BIT_UF       = 2;
	localparam int ADCSQ_BIT_OF       = 1;
	localparam int ADCSQ_BIT_RNG      = 0;
	localparam logic [3:0] ADCSQ_CH_SUPPLY = 4'h8;

	// ***************************************************************
	// Resolution codes and timing counts
	// ***************************************************************
	localparam logic [1:0] ADCSQ_RES_6  = 2'h0;
	localparam logic [1:0] ADCSQ_RES_8  = 2'h1;
	localparam logic [1:0] ADCSQ_RES_10 = 2'h2;
	localparam logic [1:0] ADCSQ_RES_12 = 2'h3;
	localparam int ADCSQ_DIV_SLOW      = 32;
	localparam int ADCSQ_DIV_FAST      = 8;
	localparam int ADCSQ_BITS_PER_TICK = 2;

	typedef enum logic [1:0] {
		ADCSQ_IDLE = 2'b01,
		ADCSQ_CONV = 2'b10
	} adcsq_state_e;

endpackage

// File: rtl/adcsq_control.sv
// Purpose: Sequencer and register file for the on-chip successive approximation converter.
// Assumes: Analog core supplies a 12-bit left-justified code and range flags asynchronously.
// Notes:   Registers sit on the CPU special function register bus.

`timescale 1ns/1ps
`default_nettype none

module adcsq_control
	import adcsq_pkg::*;
#(
	parameter int RAW_W = 12
)
(
	input  wire logic             CLK,
	input  wire logic             RESET,
	input  wire logic [7:0]       SFR_ADDR,
	input  wire logic [7:0]       SFR_WDATA,
	input  wire logic             SFR_WR,
	input  wire logic             SFR_RD,
	output logic      [7:0]       SFR_RDATA,
	input  wire logic [RAW_W-1:0] CORE_RESULT,
	input  wire logic             CORE_UNDERFLOW,
	input  wire logic             CORE_OVERFLOW,
	output logic                  ADC_POWER_ON,
	output logic                  ADC_SLEEP,
	output logic                  ADC_REF_EXTERNAL,
	output logic      [3:0]       ADC_CHANNEL,
	output logic                  ADC_DIFFERENTIAL,
	output logic      [2:0]       ADC_BIAS_TRIM,
	output logic                  ADC_CLK_TICK,
	output logic                  ADC_BUSY,
	output logic                  ADC_EOC_FLAG
);

	// ***************************************************************
	// Result formatting
	// ***************************************************************
	// Builds the high and low result bytes from a left-justified raw code.
	function automatic logic [15:0] fmt_result(input logic [1:0] res,
		input logic [RAW_W-1:0] raw, input logic uf, input logic of_);
		logic [11:0] v;
		logic [15:0] o;
		v = raw[RAW_W-1 -: 12];
		if (uf)
			v = 12'h000;                                   // RULE14
		else if (of_)
			v = 12'hFFF;                                   // RULE15
		o = 16'h0000;
		if (res == ADCSQ_RES_6)
			o = {2'h0, v[11:6], 8'h00};                    // RULE12
		else if (res == ADCSQ_RES_8)
			o = {v[11:4], 8'h00};
		else if (res == ADCSQ_RES_10)
			o = {v[11:4], v[3:2], 6'h00};                  // RULE13
		else
			o = {v[11:4], v[3:0], 4'h0};                   // RULE13
		return o;
	endfunction

	// Number of converter clock ticks needed for a resolution.
	function automatic logic [2:0] steps_for(input logic [1:0] res);
		logic [3:0] bits;
		bits = 4'(6 + 2 * int'(res));
		return 3'(bits / 4'(ADCSQ_BITS_PER_TICK));         // RULE19
	endfunction

	// ***************************************************************
	// Registers
	// ***************************************************************
	logic [7:0]       control_r;
	logic [7:0]       static_r;
	logic [7:0]       high_r;
	logic [7:0]       low_r;
	logic [7:0]       high_nxt;
	logic [7:0]       low_nxt;
	logic             eoc_r;
	logic             eoc_nxt;
	logic [4:0]       div_r;
	logic [4:0]       div_nxt;
	logic             start_s1_r;
	logic             start_s2_r;
	logic             start_s3_r;
	logic [2:0]       step_r;
	logic [2:0]       step_nxt;
	logic [1:0]       res_cap_r;
	logic [RAW_W-1:0] raw_s1_r;
	logic [RAW_W-1:0] raw_s2_r;
	logic [1:0]       flag_s1_r;
	logic [1:0]       flag_s2_r;
	adcsq_state_e     state_r;
	adcsq_state_e     state_nxt;

	// ***************************************************************
	// Decode
	// ***************************************************************
	wire logic       wr_control = SFR_WR && (SFR_ADDR == ADCSQ_ADDR_CONTROL);
	wire logic       wr_static  = SFR_WR && (SFR_ADDR == ADCSQ_ADDR_STATIC);
	wire logic       wr_extirq  = SFR_WR && (SFR_ADDR == ADCSQ_ADDR_EXTIRQ);
	wire logic       power_on   = control_r[ADCSQ_BIT_POWER];
	wire logic       run_cont   = control_r[ADCSQ_BIT_RUN];
	wire logic       fast_sel   = static_r[ADCSQ_BIT_FAST];
	wire logic [3:0] channel    = control_r[3:0];
	wire logic [1:0] res_sel    = static_r[1:0];
	wire logic [4:0] div_last   = fast_sel ? 5'(ADCSQ_DIV_FAST - 1)
	                                       : 5'(ADCSQ_DIV_SLOW - 1);
	wire logic       tick       = (div_r == div_last);                      // RULE9
	wire logic       start_edge = start_s2_r && !start_s3_r;                // RULE1
	wire logic       go_single  = start_edge && !run_cont;                  // RULE1
	wire logic       go         = tick && power_on && (run_cont || go_single); // RULE3
	wire logic       done       = (state_r == ADCSQ_CONV) && tick && (step_r == 3'h1);
	wire logic [15:0] fmt       = fmt_result(res_cap_r, raw_s2_r, flag_s2_r[1], flag_s2_r[0]);

	always_comb
	begin
		div_nxt = tick ? 5'h00 : 5'(div_r + 5'h01);
		if (div_r > div_last)
			div_nxt = 5'h00;
	end

	// ***************************************************************
	// Sequencer
	// ***************************************************************
	always_comb
	begin
		state_nxt = state_r;
		step_nxt  = step_r;
		case (state_r)
			ADCSQ_IDLE:
			begin
				if (go)
				begin
					state_nxt = ADCSQ_CONV;
					step_nxt  = steps_for(res_sel);                // RULE11
				end
			end
			ADCSQ_CONV:
			begin
				if (tick)
					step_nxt = 3'(step_r - 3'h1);
				if (done)
					state_nxt = ADCSQ_IDLE;
			end
			default:
				state_nxt = ADCSQ_IDLE;
		endcase
		if (!power_on)
			state_nxt = ADCSQ_IDLE;                                // RULE4
	end

	always_comb
	begin
		high_nxt = high_r;
		low_nxt  = low_r;
		if (done)
		begin
			high_nxt = fmt[15:8];
			low_nxt  = {fmt[7:4], 1'b0, flag_s2_r[1], flag_s2_r[0],
			            flag_s2_r[1] | flag_s2_r[0]};          // RULE16
		end
		eoc_nxt = eoc_r;
		if (wr_extirq)
			eoc_nxt = SFR_WDATA[ADCSQ_BIT_EOC];                    // RULE21
		if (done)
			eoc_nxt = 1'b1;                                        // RULE17
	end

	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			control_r <= ADCSQ_CONTROL_RST;                        // RULE18
			static_r  <= ADCSQ_STATIC_RST;                         // RULE18
			state_r   <= ADCSQ_IDLE;
			step_r    <= 3'h0;
			div_r     <= 5'h00;
			eoc_r     <= 1'b0;
			high_r    <= 8'h00;
			low_r     <= 8'h00;
			res_cap_r <= 2'h0;
		end
		else
		begin
			if (wr_control)
				control_r <= SFR_WDATA;
			if (wr_static)
				static_r <= SFR_WDATA;
			state_r <= state_nxt;
			step_r  <= step_nxt;
			div_r   <= div_nxt;
			eoc_r   <= eoc_nxt;
			high_r  <= high_nxt;
			low_r   <= low_nxt;
			if (go && state_r == ADCSQ_IDLE)
				res_cap_r <= res_sel;
		end
	end

	// ***************************************************************
	// Converter clock domain start synchroniser
	// ***************************************************************
	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			start_s1_r <= 1'b1;
			start_s2_r <= 1'b1;
			start_s3_r <= 1'b1;
		end
		else if (tick)
		begin
			start_s1_r <= control_r[ADCSQ_BIT_START];              // RULE2
			start_s2_r <= start_s1_r;                              // RULE2
			start_s3_r <= start_s2_r;
		end
	end

	// ***************************************************************
	// Analog core input synchroniser
	// ***************************************************************
	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			raw_s1_r  <= '0;
			raw_s2_r  <= '0;
			flag_s1_r <= 2'h0;
			flag_s2_r <= 2'h0;
		end
		else
		begin
			raw_s1_r  <= CORE_RESULT;
			raw_s2_r  <= raw_s1_r;
			flag_s1_r <= {CORE_UNDERFLOW, CORE_OVERFLOW};
			flag_s2_r <= flag_s1_r;
		end
	end

	// ***************************************************************
	// Read mux and core controls
	// ***************************************************************
	wire logic [7:0] eoc_byte = {3'h0, eoc_r, 4'h0};

	assign SFR_RDATA = !SFR_RD ? 8'h00
		: (SFR_ADDR == ADCSQ_ADDR_CONTROL) ? control_r
		: (SFR_ADDR == ADCSQ_ADDR_HIGH)    ? high_r
		: (SFR_ADDR == ADCSQ_ADDR_LOW)     ? low_r
		: (SFR_ADDR == ADCSQ_ADDR_STATIC)  ? static_r
		: (SFR_ADDR == ADCSQ_ADDR_EXTIRQ)  ? eoc_byte
		: 8'h00;

	assign ADC_POWER_ON     = power_on;                                 // RULE4
	assign ADC_SLEEP        = static_r[ADCSQ_BIT_SLEEP];                // RULE8
	assign ADC_REF_EXTERNAL = control_r[ADCSQ_BIT_REF] &&
	                          (channel != ADCSQ_CH_SUPPLY);             // RULE5
	assign ADC_CHANNEL      = channel;                                  // RULE6
	assign ADC_DIFFERENTIAL = static_r[ADCSQ_BIT_DIFF];                 // RULE7
	assign ADC_BIAS_TRIM    = static_r[4:2];                            // RULE10
	assign ADC_CLK_TICK     = tick;
	assign ADC_BUSY         = (state_r == ADCSQ_CONV);
	assign ADC_EOC_FLAG     = eoc_r;                                    // RULE20

	// ***************************************************************
	// Assertions
	// ***************************************************************
	// Counts converter ticks inside one conversion for the length checks.
	logic [2:0]       conv_ticks_r;

	always_ff @(posedge CLK)
	begin
		if (RESET || state_r != ADCSQ_CONV)
			conv_ticks_r <= 3'h0;
		else if (tick)
			conv_ticks_r <= 3'(conv_ticks_r + 3'h1);
	end

	a_eoc_on_done: assert property (@(posedge CLK) disable iff (RESET) // RULE17
		done |=> eoc_r) else $error("end of conversion flag not set");
	a_set_wins: assert property (@(posedge CLK) disable iff (RESET) // RULE21
		done && wr_extirq && !SFR_WDATA[ADCSQ_BIT_EOC] |=> eoc_r)
		else $error("flag clear beat completion");
	a_run_starts: assert property (@(posedge CLK) disable iff (RESET) // RULE3
		state_r == ADCSQ_IDLE && tick && power_on && run_cont |=> ADC_BUSY)
		else $error("continuous run did not start");
	a_power_down: assert property (@(posedge CLK) disable iff (RESET) // RULE4
		!power_on |=> !ADC_BUSY) else $error("converter busy while powered down");
	a_supply_ref: assert property (@(posedge CLK) disable iff (RESET) // RULE5
		channel == ADCSQ_CH_SUPPLY |-> !ADC_REF_EXTERNAL)
		else $error("external reference on supply channel");
	a_fast_div: assert property (@(posedge CLK) disable iff (RESET) // RULE9
		tick && fast_sel ##1 (fast_sel && !wr_static)[*7] |=> tick)
		else $error("fast divider period wrong");
	a_range_or: assert property (@(posedge CLK) disable iff (RESET) // RULE16
		low_r[ADCSQ_BIT_RNG] == (low_r[ADCSQ_BIT_UF] | low_r[ADCSQ_BIT_OF]))
		else $error("range flag mismatch");
	a_uf_zero: assert property (@(posedge CLK) disable iff (RESET) // RULE14
		done && flag_s2_r[1] |=> high_r == 8'h00 && low_r[7:4] == 4'h0)
		else $error("underflow result not zero");
	a_of_ones: assert property (@(posedge CLK) disable iff (RESET) // RULE15
		done && !flag_s2_r[1] && flag_s2_r[0] && res_cap_r == ADCSQ_RES_12
		|=> high_r == 8'hFF && low_r[7:4] == 4'hF)
		else $error("overflow result not all ones");
	a_six_bit: assert property (@(posedge CLK) disable iff (RESET) // RULE12
		done && res_cap_r == ADCSQ_RES_6 |=> high_r[7:6] == 2'h0)
		else $error("six bit result has upper bits");
	a_six_len: assert property (@(posedge CLK) disable iff (RESET) // RULE19
		done && res_cap_r == ADCSQ_RES_6 |-> conv_ticks_r == 3'h2)
		else $error("six bit conversion length wrong");
	a_twelve_len: assert property (@(posedge CLK) disable iff (RESET) // RULE19
		done && res_cap_r == ADCSQ_RES_12 |-> conv_ticks_r == 3'h5)
		else $error("twelve bit conversion length wrong");

	c_single: cover property (@(posedge CLK) disable iff (RESET) go_single && go);
	c_cont: cover property (@(posedge CLK) disable iff (RESET) run_cont && done);
	c_twelve: cover property (@(posedge CLK) disable iff (RESET)
		done && res_cap_r == ADCSQ_RES_12);
	c_over: cover property (@(posedge CLK) disable iff (RESET) done && flag_s2_r[0]);

endmodule

`default_nettype wire

// File: verif/tb_top.sv
// Purpose: Self-checking bench for the converter sequencer control block.
// Assumes: Register bus driven 5 ns after each rising edge; core inputs held steady.
// Notes:   Conversions run at the fast divider to keep the run short.

`timescale 1ns/1ps
`default_nettype none

module tb_top
	import adcsq_pkg::*;
;
	logic        CLK = 1'b0;
	logic        RESET = 1'b1;
	logic [7:0]  SFR_ADDR = 8'h00;
	logic [7:0]  SFR_WDATA = 8'h00;
	logic        SFR_WR = 1'b0;
	logic        SFR_RD = 1'b0;
	logic [7:0]  SFR_RDATA;
	logic [11:0] CORE_RESULT = 12'hAB5;
	logic        CORE_UNDERFLOW = 1'b0;
	logic        CORE_OVERFLOW = 1'b0;
	logic        ADC_POWER_ON, ADC_SLEEP, ADC_REF_EXTERNAL, ADC_DIFFERENTIAL;
	logic [3:0]  ADC_CHANNEL;
	logic [2:0]  ADC_BIAS_TRIM;
	logic        ADC_CLK_TICK, ADC_BUSY, ADC_EOC_FLAG;
	int          mismatches = 0;
	int          num_checks = 0;
	int          cycles = 0;

	adcsq_control dut_u (.CLK(CLK), .RESET(RESET), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA),
		.SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA), .CORE_RESULT(CORE_RESULT),
		.CORE_UNDERFLOW(CORE_UNDERFLOW), .CORE_OVERFLOW(CORE_OVERFLOW),
		.ADC_POWER_ON(ADC_POWER_ON), .ADC_SLEEP(ADC_SLEEP), .ADC_REF_EXTERNAL(ADC_REF_EXTERNAL),
		.ADC_CHANNEL(ADC_CHANNEL), .ADC_DIFFERENTIAL(ADC_DIFFERENTIAL),
		.ADC_BIAS_TRIM(ADC_BIAS_TRIM), .ADC_CLK_TICK(ADC_CLK_TICK), .ADC_BUSY(ADC_BUSY),
		.ADC_EOC_FLAG(ADC_EOC_FLAG));

	always #25 CLK = ~CLK;

	// ***************************************************************
	// Shared tasks
	// ***************************************************************
	task automatic results();
		$display("Checks %0d, mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	always @(posedge CLK)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			results();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cyc();
		@(posedge CLK);
		#5;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		cyc();
		SFR_RD = 1'b0;
		SFR_ADDR = a;
		SFR_WDATA = d;
		SFR_WR = 1'b1;
		cyc();
		SFR_WR = 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		cyc();
		SFR_ADDR = a;
		SFR_RD = 1'b1;
		#1;
		chk(SFR_RDATA, exp);
	endtask

	task automatic wait_tick();
		int n;
		n = 0;
		cyc();
		while (ADC_CLK_TICK !== 1'b1 && n < 100)
		begin
			cyc();
			n++;
		end
	endtask

	task automatic wait_eoc();
		int n;
		n = 0;
		while (ADC_EOC_FLAG !== 1'b1 && n < 1000)
		begin
			cyc();
			n++;
		end
		chk({7'h00, ADC_EOC_FLAG}, 8'h01);
	endtask

	// Start bit high, low for four ticks, then high again.
	task automatic single_conv(input logic [7:0] res_static, input logic [7:0] exp_h,
		input logic [7:0] exp_l);
		wr(ADCSQ_ADDR_STATIC, res_static);
		wr(ADCSQ_ADDR_EXTIRQ, 8'h00);
		wr(ADCSQ_ADDR_CONTROL, 8'h20);
		repeat (4) wait_tick();
		wr(ADCSQ_ADDR_CONTROL, 8'hA0);
		wait_eoc();
		rd_chk(ADCSQ_ADDR_HIGH, exp_h);
		rd_chk(ADCSQ_ADDR_LOW, exp_l);
		rd_chk(ADCSQ_ADDR_EXTIRQ, 8'h10);
	endtask

	// ***************************************************************
	// Scenarios
	// ***************************************************************
	task automatic t_reset();
		rd_chk(ADCSQ_ADDR_CONTROL, 8'h80);
		rd_chk(ADCSQ_ADDR_STATIC, 8'h0A);
		rd_chk(8'h55, 8'h00);
		chk({5'h00, ADC_BIAS_TRIM}, 8'h02);
		chk({7'h00, ADC_POWER_ON}, 8'h00);
		$display("Test reset done");
	endtask

	task automatic t_config();
		wr(ADCSQ_ADDR_CONTROL, 8'hB8);
		chk({3'h0, ADC_REF_EXTERNAL, ADC_CHANNEL}, 8'h08);
		wr(ADCSQ_ADDR_CONTROL, 8'hB3);
		chk({3'h0, ADC_REF_EXTERNAL, ADC_CHANNEL}, 8'h13);
		wr(ADCSQ_ADDR_STATIC, 8'hDF);
		chk({5'h00, ADC_DIFFERENTIAL, ADC_SLEEP, ADC_POWER_ON}, 8'h07);
		chk({5'h00, ADC_BIAS_TRIM}, 8'h07);
		rd_chk(ADCSQ_ADDR_STATIC, 8'hDF);
		$display("Test config done");
	endtask

	task automatic t_divider(input logic [7:0] st, input int exp);
		int n;
		wr(ADCSQ_ADDR_STATIC, st);
		wait_tick();
		wait_tick();
		n = 1;
		cyc();
		while (ADC_CLK_TICK !== 1'b1 && n < 100)
		begin
			cyc();
			n++;
		end
		chk(n[7:0], exp[7:0]);
		$display("Test divider done");
	endtask

	task automatic t_continuous();
		wr(ADCSQ_ADDR_STATIC, 8'h2B);
		wr(ADCSQ_ADDR_EXTIRQ, 8'h00);
		wr(ADCSQ_ADDR_CONTROL, 8'h60);
		wait_eoc();
		wr(ADCSQ_ADDR_EXTIRQ, 8'h00);
		rd_chk(ADCSQ_ADDR_EXTIRQ, 8'h00);
		wait_eoc();
		wr(ADCSQ_ADDR_CONTROL, 8'h40);
		cyc();
		chk({6'h00, ADC_BUSY, ADC_POWER_ON}, 8'h00);
		wr(ADCSQ_ADDR_EXTIRQ, 8'h00);
		repeat (200) cyc();
		chk({7'h00, ADC_EOC_FLAG}, 8'h00);
		$display("Test continuous done");
	endtask

	// Clears the flag in every cycle of a continuous run; the completion must still win.
	task automatic t_set_wins();
		logic prev;
		int   n;
		wr(ADCSQ_ADDR_STATIC, 8'h28);
		wr(ADCSQ_ADDR_CONTROL, 8'h60);
		cyc();
		SFR_ADDR = ADCSQ_ADDR_EXTIRQ;
		SFR_WDATA = 8'h00;
		SFR_WR = 1'b1;
		prev = 1'b0;
		n = 0;
		while (!(prev === 1'b1 && ADC_BUSY === 1'b0) && n < 200)
		begin
			prev = ADC_BUSY;
			cyc();
			n++;
		end
		chk({7'h00, ADC_EOC_FLAG}, 8'h01);
		SFR_WR = 1'b0;
		$display("Test set wins done");
	endtask

	initial
	begin
		repeat (2) @(posedge CLK);
		#5;
		RESET = 1'b0;
		t_reset();
		t_config();
		t_divider(8'h2B, 8);
		t_divider(8'h0B, 32);
		wr(ADCSQ_ADDR_CONTROL, 8'hA0);
		single_conv(8'h28, 8'h2A, 8'h00);
		single_conv(8'h29, 8'hAB, 8'h00);
		single_conv(8'h2A, 8'hAB, 8'h40);
		single_conv(8'h2B, 8'hAB, 8'h50);
		CORE_UNDERFLOW = 1'b1;
		single_conv(8'h2B, 8'h00, 8'h05);
		CORE_UNDERFLOW = 1'b0;
		CORE_OVERFLOW = 1'b1;
		single_conv(8'h2B, 8'hFF, 8'hF3);
		CORE_OVERFLOW = 1'b0;
		$display("Test conversions done");
		t_continuous();
		t_set_wins();
		results();
	end

endmodule

`default_nettype wire
